//--- design/fsp_pkg.sv
// Package with constants and types shared by the self-programming controller ends.
package fsp_pkg;
    // Register offset and control bit positions.
    localparam logic [7:0] FSP_CSR_ADDR = 8'h37;
    localparam logic [7:0] FSP_CSR_RESET = 8'h00;
    localparam int FSP_BIT_EN = 0;
    localparam int FSP_BIT_ERASE = 1;
    localparam int FSP_BIT_WRITE = 2;
    localparam int FSP_BIT_RFL = 3;
    localparam int FSP_BIT_CLR = 4;
    // Accepted command patterns in the lower five control bits.
    localparam logic [4:0] FSP_CMD_LOAD = 5'h01;
    localparam logic [4:0] FSP_CMD_ERASE = 5'h03;
    localparam logic [4:0] FSP_CMD_WRITE = 5'h05;
    localparam logic [4:0] FSP_CMD_RFL = 5'h09;
    localparam logic [4:0] FSP_CMD_CLR = 5'h11;
    // Arming windows in cycles.
    localparam logic [2:0] FSP_STORE_WIN = 3'h4;
    localparam logic [2:0] FSP_LOAD_WIN = 3'h3;
    // Fuse/lock read pointers.
    localparam logic [15:0] FSP_PTR_FUSE_LO = 16'h0000;
    localparam logic [15:0] FSP_PTR_LOCK = 16'h0001;
    localparam logic [15:0] FSP_PTR_FUSE_HI = 16'h0003;
    // Flash operation time in nanoseconds and clock period.
    localparam longint FSP_T_OP_MIN_NS = 64'd3700000;
    localparam longint FSP_T_OP_MAX_NS = 64'd4500000;
    localparam longint FSP_CLK_NS = 64'd50;
    localparam longint FSP_OP_MIN_CYC = (FSP_T_OP_MIN_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
    localparam longint FSP_OP_MAX_CYC = FSP_T_OP_MAX_NS / FSP_CLK_NS;
    // Flash array operation codes.
    typedef enum logic [1:0] {
        FSP_OP_NONE = 2'b00,
        FSP_OP_ERASE = 2'b01,
        FSP_OP_WRITE = 2'b10
    } fsp_op_t;
endpackage

//--- design/fsp_if.sv
// Interface joining the processor-side master and the self-programming controller.
`timescale 1ns/100ps
`default_nettype none
interface fsp_if;
    logic csr_wr;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic store_program_instruction;
    logic load_program_instruction;
    logic [15:0] pointer;
    logic [15:0] data_register_pair;
    logic [7:0] load_data;
    logic load_valid;
    logic cpu_stall;
    logic eeprom_write_busy_flag;
    modport device (
        input csr_wr, csr_wdata, store_program_instruction, load_program_instruction,
        input pointer, data_register_pair, eeprom_write_busy_flag,
        output csr_rdata, load_data, load_valid, cpu_stall
    );
    modport core (
        output csr_wr, csr_wdata, store_program_instruction, load_program_instruction,
        output pointer, data_register_pair, eeprom_write_busy_flag,
        input csr_rdata, load_data, load_valid, cpu_stall
    );
endinterface
`default_nettype wire

//--- design/fsp_page_buffer.sv
// Temporary page buffer with per-word valid flags and whole-buffer clear.
`timescale 1ns/100ps
`default_nettype none
module fsp_page_buffer
    import fsp_pkg::*;
#(
    parameter int WORDS = 32,
    parameter int IW = 5
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic clear,
    input wire logic [IW-1:0] rd_idx,
    output logic [15:0] rd_data,
    output logic rd_valid
);
    logic [15:0] mem [WORDS];
    logic [WORDS-1:0] valid;

    // Valid flags drop on clear; an unloaded word reads as erased flash.
    genvar g;
    for (g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                valid[g] <= 1'b0;
            end else if (clear) begin
                valid[g] <= 1'b0;
            end else if (wr_en && wr_idx == IW'(g)) begin
                valid[g] <= 1'b1;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (wr_en && wr_idx == IW'(g)) begin
                mem[g] <= wr_data;
            end
        end
    end

    assign rd_valid = valid[rd_idx];
    assign rd_data = valid[rd_idx] ? mem[rd_idx] : 16'hffff;
endmodule
`default_nettype wire

//--- design/fsp_ctrl.sv
// Self-programming controller: control register, page buffer and flash sequencing.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE1 - 00000001 plus store loads pair into buffer
// RULE2 - Buffer clears after write, clear bit, reset
// RULE3 - Software never loads a word twice
// RULE4 - EEPROM write during loading discards buffer
// RULE5 - 00000101 plus store writes pointer page
// RULE6 - Processor stalls for whole page write
// RULE7 - Low pointer bits word, high bits page
// RULE8 - Software uses same page erase and write
// RULE9 - Load reads bytes; store ignores byte select
// RULE10 - EEPROM busy blocks programming and fuse reads
// RULE11 - Software polls EEPROM busy before control write
// RULE12 - Pointer 0001 read returns two lock bits
// RULE13 - Pointers 0000/0003 return low/high fuse bytes
// RULE14 - Read bits clear on read or timeout
// RULE15 - Programmed bits read zero, unprogrammed one
// RULE16 - Reset lets running flash write finish
// RULE17 - Erase/write last 3.7 to 4.5 ms
// RULE18 - Control bits 7:5 read zero
// RULE19 - Clear bit while filling empties buffer
// RULE20 - Write bit arms store, self-clears
// RULE21 - Erase bit arms store, self-clears, stalls
// RULE22 - Enable arms four cycles, holds during operation
// RULE23 - 00000011 plus store erases pointer page
// RULE24 - Other patterns ignored without side effect
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int WORD_BITS = 5,
    parameter int PAGE_BITS = 7,
    parameter int OP_CYCLES = int'(FSP_OP_MIN_CYC),
    parameter logic [7:0] FUSE_LOW = 8'h62,
    parameter logic [7:0] FUSE_HIGH = 8'hdf,
    parameter logic [1:0] LOCK_BITS = 2'h3
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic por_b,
    fsp_if.device bus,
    output logic flash_start,
    output fsp_op_t flash_op,
    output logic [PAGE_BITS-1:0] flash_page,
    output logic [WORD_BITS-1:0] flash_word_idx,
    input wire logic [WORD_BITS-1:0] flash_rd_word_idx,
    output logic [15:0] flash_wdata,
    output logic flash_wvalid,
    output logic flash_busy
);
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_ARMED = 2'b01,
        FSP_BUSY = 2'b10
    } fsp_state_t;

    fsp_state_t state;
    fsp_state_t next_state;
    logic [4:0] ctrl;
    logic [4:0] next_ctrl;
    logic [2:0] win;
    logic [2:0] next_win;
    logic [31:0] op_cnt;
    logic loading;
    logic eep_busy;

    // The EEPROM busy flag comes from logic on this same clock, so it is used as is.
    // Extra flops here would let a command slip in during the first busy cycles.
    assign eep_busy = bus.eeprom_write_busy_flag; // RULE10

    wire [4:0] wcmd = bus.csr_wdata[4:0];
    wire cmd_ok = wcmd == FSP_CMD_LOAD || wcmd == FSP_CMD_ERASE || wcmd == FSP_CMD_WRITE
        || wcmd == FSP_CMD_RFL || wcmd == FSP_CMD_CLR; // RULE24
    wire fuse_cmd = wcmd == FSP_CMD_RFL;
    wire csr_take = bus.csr_wr && state == FSP_IDLE && cmd_ok
        && !(eep_busy && wcmd != FSP_CMD_CLR); // RULE10
    wire do_clear = csr_take && wcmd == FSP_CMD_CLR; // RULE19
    wire armed = state == FSP_ARMED;
    wire store_hit = armed && bus.store_program_instruction && ctrl != FSP_CMD_RFL;
    wire load_hit = armed && bus.load_program_instruction && ctrl == FSP_CMD_RFL && !eep_busy;
    wire buf_load = store_hit && ctrl == FSP_CMD_LOAD; // RULE1
    wire op_start = store_hit && (ctrl == FSP_CMD_ERASE || ctrl == FSP_CMD_WRITE); // RULE5 RULE23
    wire win_limit_hit = win == 3'h1;
    wire [WORD_BITS-1:0] word_idx = bus.pointer[WORD_BITS:1]; // RULE7 RULE9
    wire [PAGE_BITS-1:0] page_idx = bus.pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1]; // RULE7
    wire op_done = state == FSP_BUSY && op_cnt == 32'(OP_CYCLES - 1);
    wire eep_kill = loading && eep_busy; // RULE4
    wire buf_clear = do_clear || eep_kill || (op_done && flash_op == FSP_OP_WRITE); // RULE2

    // Command sequencing; enable and command bits hold through the whole operation.
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_win = win;
        case (state)
            FSP_IDLE: begin
                if (csr_take && !do_clear) begin
                    next_state = FSP_ARMED;
                    next_ctrl = wcmd;
                    next_win = fuse_cmd ? FSP_LOAD_WIN : FSP_STORE_WIN; // RULE14 RULE22
                end
            end
            FSP_ARMED: begin
                if (op_start) begin
                    next_state = FSP_BUSY; // RULE22
                end else if (store_hit || load_hit || win_limit_hit) begin
                    next_state = FSP_IDLE; // RULE14 RULE20 RULE21 RULE22
                    next_ctrl = 5'h00;
                end else begin
                    next_win = win - 3'h1;
                end
            end
            FSP_BUSY: begin
                if (op_done) begin
                    next_state = FSP_IDLE; // RULE20 RULE21
                    next_ctrl = 5'h00;
                end
            end
            default: begin
                next_state = FSP_IDLE;
                next_ctrl = 5'h00;
            end
        endcase
    end

    // The sequencer rides on power-on reset so a system reset cannot cut a running operation short.
    always_ff @(posedge sys_clk or negedge por_b) begin
        if (!por_b) begin
            state <= FSP_IDLE;
            ctrl <= 5'h00;
            win <= 3'h0;
        end else begin
            state <= next_state; // RULE16
            ctrl <= next_ctrl;
            win <= next_win;
        end
    end

    // Operation timer sets the erase/write duration.
    always_ff @(posedge sys_clk or negedge por_b) begin
        if (!por_b) begin
            op_cnt <= 32'h0;
            flash_op <= FSP_OP_NONE;
            flash_page <= '0;
        end else if (op_start) begin
            op_cnt <= 32'h0;
            flash_op <= (ctrl == FSP_CMD_WRITE) ? FSP_OP_WRITE : FSP_OP_ERASE;
            flash_page <= page_idx; // RULE5 RULE23
        end else if (state == FSP_BUSY) begin
            op_cnt <= op_cnt + 32'h1; // RULE17
            if (op_done) begin
                flash_op <= FSP_OP_NONE;
            end
        end
    end

    // Loading is tracked so an EEPROM write mid-fill can discard the partial page.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            loading <= 1'b0;
        end else if (buf_clear) begin
            loading <= 1'b0;
        end else if (buf_load) begin
            loading <= 1'b1;
        end
    end

    // Fuse and lock read, plain flash reads pass through the core; programmed bits read zero.
    wire [7:0] fuse_val = (bus.pointer == FSP_PTR_LOCK) ? {6'h3f, LOCK_BITS} // RULE12 RULE15
        : (bus.pointer == FSP_PTR_FUSE_HI) ? FUSE_HIGH // RULE13
        : (bus.pointer == FSP_PTR_FUSE_LO) ? FUSE_LOW : 8'hff;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.load_data <= 8'h00;
            bus.load_valid <= 1'b0;
        end else begin
            bus.load_valid <= load_hit;
            if (load_hit) begin
                bus.load_data <= fuse_val;
            end
        end
    end

    fsp_page_buffer #(
        .WORDS(1 << WORD_BITS),
        .IW(WORD_BITS)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(buf_load && !buf_clear),
        .wr_idx(word_idx),
        .wr_data(bus.data_register_pair),
        .clear(buf_clear || !rst_b),
        .rd_idx(flash_rd_word_idx),
        .rd_data(flash_wdata),
        .rd_valid(flash_wvalid)
    );

    assign bus.csr_rdata = {3'h0, ctrl}; // RULE18
    assign bus.cpu_stall = state == FSP_BUSY; // RULE6 RULE21
    assign flash_start = op_start;
    assign flash_busy = state == FSP_BUSY;
    assign flash_word_idx = word_idx;
endmodule
`default_nettype wire

//--- design/fsp_core_port.sv
// Processor-side end: turns a plain register port into control writes and program instructions.
`timescale 1ns/100ps
`default_nettype none
module fsp_core_port
    import fsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic store_req,
    input wire logic load_req,
    input wire logic [15:0] pointer,
    input wire logic eeprom_busy,
    output logic stalled,
    fsp_if.core bus
);
    // Control writes go straight to the device; software should first see the EEPROM idle.
    assign bus.csr_wr = wr && addr == FSP_CSR_ADDR && !bus.cpu_stall; // RULE11
    assign bus.csr_wdata = wdata[7:0];
    assign bus.store_program_instruction = store_req && !bus.cpu_stall; // RULE3 RULE8
    assign bus.load_program_instruction = load_req && !bus.cpu_stall;
    assign bus.pointer = pointer;
    assign bus.data_register_pair = wdata;
    assign bus.eeprom_write_busy_flag = eeprom_busy;
    assign stalled = bus.cpu_stall;

    // Read data stand one cycle after the strobe; fuse data override when returned.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (bus.load_valid) begin
            rdata <= {8'h00, bus.load_data};
        end else if (rd) begin
            rdata <= (addr == FSP_CSR_ADDR) ? {8'h00, bus.csr_rdata} : 16'h0000;
        end
    end
endmodule
`default_nettype wire

//--- dv/fsp_asserts.sv
// Concurrent checks on the link between the processor port and the controller.
`timescale 1ns/100ps
`default_nettype none
module fsp_asserts
    import fsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    input wire logic [7:0] csr_rdata,
    input wire logic store_program_instruction,
    input wire logic load_program_instruction,
    input wire logic load_valid,
    input wire logic cpu_stall,
    input wire logic eeprom_write_busy_flag
);
    // Decode of the accepted command patterns in the lower five bits.
    wire logic [4:0] cmd = csr_wdata[4:0];
    wire logic cmd_ok = cmd == FSP_CMD_LOAD || cmd == FSP_CMD_ERASE || cmd == FSP_CMD_WRITE || cmd == FSP_CMD_RFL
        || cmd == FSP_CMD_CLR;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    reserved_zero_a: assert property (csr_rdata[7:5] == 3'h0)
        else $error("Reserved control bits read nonzero.");
    load_lapse_a: assert property ($rose(csr_rdata == 8'h01) |-> ##[1:4] csr_rdata == 8'h00)
        else $error("Buffer load arming outlived its window.");
    fuse_lapse_a: assert property ($rose(csr_rdata == 8'h09) |-> ##[1:3] csr_rdata == 8'h00)
        else $error("Fuse read arming outlived its window.");
    write_stall_a: assert property (csr_rdata == 8'h05 && store_program_instruction |=> cpu_stall)
        else $error("Page write did not stall the processor.");
    stall_holds_a: assert property ($rose(cpu_stall) |-> cpu_stall [*8])
        else $error("Processor stall ended too soon.");
    enable_held_a: assert property (cpu_stall |-> csr_rdata[0] && (csr_rdata[1] || csr_rdata[2]))
        else $error("Enable or operation bit dropped during an operation.");
    busy_blocks_a: assert property (eeprom_write_busy_flag [*3] ##0 (csr_wr && !csr_wdata[4] && csr_rdata == 8'h00)
        |=> csr_rdata == 8'h00)
        else $error("Command accepted while the EEPROM was busy.");
    bad_pattern_a: assert property (csr_wr && !cmd_ok && csr_rdata == 8'h00 |=> csr_rdata == 8'h00)
        else $error("Unaccepted pattern changed the control register.");
    fuse_answer_a: assert property (csr_rdata == 8'h09 && load_program_instruction && !eeprom_write_busy_flag
        |=> load_valid)
        else $error("Fuse read gave no answer in the next cycle.");

    // Main scenarios that the bench must reach.
    cover property ($rose(cpu_stall));
    cover property (load_valid);
    cover property (csr_rdata == 8'h01 && store_program_instruction);
endmodule
`default_nettype wire

//--- dv/flash_self_program_ctrl_bench.sv
// Self-checking bench for the processor port and the controller joined back to back.
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_ctrl_bench
    import fsp_pkg::*;
;
    localparam int OPC = 20;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic store_req = 1'b0;
    logic load_req = 1'b0;
    logic [15:0] pointer = 16'h0000;
    logic eeprom_busy = 1'b0;
    logic [4:0] rd_idx = 5'h00;
    logic [15:0] rdata;
    logic stalled;
    logic flash_start;
    logic [4:0] flash_word_idx;
    fsp_op_t flash_op;
    logic [6:0] flash_page;
    logic [15:0] flash_wdata;
    logic flash_wvalid;
    logic flash_busy;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;

    // Free-running system clock at 20 MHz.
    always #25 sys_clk = ~sys_clk;

    fsp_if u_fsp_if();
    fsp_core_port u_fsp_core_port(.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .store_req(store_req), .load_req(load_req), .pointer(pointer), .eeprom_busy(eeprom_busy),
        .stalled(stalled), .bus(u_fsp_if.core));
    // Fuse values are arbitrary; the lock pair mixes a programmed and an unprogrammed bit.
    fsp_ctrl #(.OP_CYCLES(OPC), .FUSE_LOW(8'h5a), .FUSE_HIGH(8'hc3), .LOCK_BITS(2'h2)) u_fsp_ctrl(
        .sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b), .bus(u_fsp_if.device), .flash_start(flash_start),
        .flash_op(flash_op), .flash_page(flash_page), .flash_word_idx(flash_word_idx),
        .flash_rd_word_idx(rd_idx), .flash_wdata(flash_wdata),
        .flash_wvalid(flash_wvalid), .flash_busy(flash_busy));
    fsp_asserts u_fsp_asserts(.sys_clk(sys_clk), .rst_b(rst_b), .csr_wr(u_fsp_if.csr_wr),
        .csr_wdata(u_fsp_if.csr_wdata), .csr_rdata(u_fsp_if.csr_rdata),
        .store_program_instruction(u_fsp_if.store_program_instruction),
        .load_program_instruction(u_fsp_if.load_program_instruction), .load_valid(u_fsp_if.load_valid),
        .cpu_stall(u_fsp_if.cpu_stall), .eeprom_write_busy_flag(u_fsp_if.eeprom_write_busy_flag));

    // Waits for edges and steps past them so that sampled outputs have settled.
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is counted as a mismatch and ends the run.
    task automatic give_up();
        error_cnt++;
        tally_and_finish();
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        rd <= 1'b1;
        addr <= a;
        tick(1);
        rd <= 1'b0;
        chk16(rdata, exp);
        // One idle edge keeps a following read from re-raising the strobe in the same step.
        tick(1);
    endtask

    task automatic csr(input logic [7:0] d);
        wr <= 1'b1;
        addr <= FSP_CSR_ADDR;
        wdata <= {8'h00, d};
        tick(1);
        wr <= 1'b0;
    endtask

    task automatic store(input logic [15:0] p, input logic [15:0] d);
        store_req <= 1'b1;
        pointer <= p;
        wdata <= d;
        tick(1);
        store_req <= 1'b0;
    endtask

    // Buffer load with the byte select set, which the load must ignore.
    task automatic ld(input logic [4:0] idx, input logic [15:0] d);
        csr({3'h0, FSP_CMD_LOAD});
        store({3'h0, 7'h15, idx, 1'b1}, d);
        tick(2);
        chk16({11'h0, flash_word_idx}, {11'h0, idx});
    endtask

    task automatic bufchk(input logic [4:0] idx, input logic v, input logic [15:0] d);
        rd_idx <= idx;
        #1;
        chk16({15'h0, flash_wvalid}, {15'h0, v});
        chk16(flash_wdata, d);
    endtask

    task automatic fuse(input logic [15:0] p, input logic [7:0] m, input logic [7:0] e);
        csr({3'h0, FSP_CMD_RFL});
        load_req <= 1'b1;
        pointer <= p;
        tick(1);
        load_req <= 1'b0;
        n = 0;
        while (u_fsp_if.load_valid !== 1'b1) begin
            if (n == 8) give_up();
            tick(1);
            n++;
        end
        chk16({8'h00, u_fsp_if.load_data & m}, {8'h00, e});
        tick(1);
        chk16(rdata & {8'h00, m}, {8'h00, e});
    endtask

    // Erase or write, optionally with a system reset pulsed in mid-operation.
    task automatic op(input logic [4:0] c, input logic [6:0] pg, input fsp_op_t o, input logic rs);
        csr({3'h0, c});
        store_req <= 1'b1;
        pointer <= {3'h0, pg, 6'h00};
        wdata <= 16'h1234;
        #1;
        chk16({15'h0, flash_start}, 16'h0001);
        tick(1);
        store_req <= 1'b0;
        tick(1);
        chk16({15'h0, stalled}, 16'h0001);
        chk16({14'h0, flash_op}, {14'h0, o});
        chk16({9'h0, flash_page}, {9'h0, pg});
        n = 0;
        if (rs) begin
            rst_b <= 1'b0;
            tick(2);
            rst_b <= 1'b1;
            tick(1);
            chk16({15'h0, flash_busy}, 16'h0001);
            n = 3;
        end
        while (u_fsp_if.cpu_stall === 1'b1) begin
            if (n == 3 * OPC) give_up();
            tick(1);
            n++;
        end
        chk16({15'h0, n >= OPC - 3 && n <= OPC}, 16'h0001);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0000);
    endtask

    // Main sequence.
    initial begin
        tick(2);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        tick(1);
        chk16({8'h00, u_fsp_if.csr_rdata}, {8'h00, FSP_CSR_RESET});
        rd_reg(FSP_CSR_ADDR, 16'h0000);
        rd_reg(8'h00, 16'h0000);
        csr(8'h07);
        tick(2);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0000);
        csr(8'he1);
        tick(1);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0001);
        rd_reg(FSP_CSR_ADDR, 16'h0001);
        tick(5);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0000);
        ld(5'h00, 16'hbee0);
        ld(5'h1f, 16'h7c1f);
        bufchk(5'h00, 1'b1, 16'hbee0);
        bufchk(5'h1f, 1'b1, 16'h7c1f);
        csr({3'h0, FSP_CMD_CLR});
        tick(3);
        bufchk(5'h00, 1'b0, 16'hffff);
        ld(5'h05, 16'h5555);
        eeprom_busy <= 1'b1;
        tick(4);
        bufchk(5'h05, 1'b0, 16'hffff);
        csr({3'h0, FSP_CMD_RFL});
        tick(1);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0000);
        eeprom_busy <= 1'b0;
        tick(4);
        fuse(FSP_PTR_FUSE_LO, 8'hff, 8'h5a);
        fuse(FSP_PTR_FUSE_HI, 8'hff, 8'hc3);
        fuse(FSP_PTR_LOCK, 8'h03, 8'h02);
        csr({3'h0, FSP_CMD_RFL});
        tick(5);
        chk16({8'h00, u_fsp_if.csr_rdata}, 16'h0000);
        op(FSP_CMD_ERASE, 7'h15, FSP_OP_ERASE, 1'b1);
        ld(5'h02, 16'h0f0f);
        op(FSP_CMD_WRITE, 7'h15, FSP_OP_WRITE, 1'b0);
        bufchk(5'h02, 1'b0, 16'hffff);
        tally_and_finish();
    end
endmodule
`default_nettype wire
